// >>> ddcc_channel_ctrl.sv
// downconverter channel control: register slave, sync, mixer, gain and decimation select
//
// Overview of operation
// - In one-shot mode only the first valid SYSREF edge aligns the oscillator.
// - Sync enable zero disables sync; one-shot clears the enable after next edge.
// - Mixer bit: zero real mixer from one channel, one complex from two channels.
// - Gain bit: zero unity gain, one doubles output for 6 dB.
// - IF mode: variable, zero hertz, half-sample-rate IF, or test mode.
// - Complex-to-real bit: zero gives I and Q, one gives real I only.
// - Codes 000 to 011 pick halfband chains decimating 4, 8, 16, 2 complex.
// - Codes 100 to 110 add thirdband two, decimating 6, 12, 24 complex.
// - Code 111 hands chain selection to the extended four-bit rate field.
`timescale 1ns/10ps
module ddcc_channel_ctrl
	import ddcc_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [ADR_W-1:0]        wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [DAT_W-1:0]        wb_dat_i,
	output logic      [DAT_W-1:0]        wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    sysrefIn,
	input  wire logic                    sampleValid,
	input  wire logic signed [SMP_W-1:0] chanASample,
	input  wire logic signed [SMP_W-1:0] chanBSample,
	output logic                         outValid,
	output logic signed [SMP_W-1:0]      outI,
	output logic signed [SMP_W-1:0]      outQ,
	output logic                         oscRestart
);

	// register state
	logic [7:0]       syncCtrl_r;
	logic [7:0]       syncCtrl_nxt;
	logic [7:0]       chanCtrl_r;
	logic [7:0]       auxCtrl_r;
	logic [PH_W-1:0]  ftw_r;
	logic [PH_W-1:0]  pow_r;
	logic             ack_r;
	logic [DAT_W-1:0] rdData_r;
	logic [7:0]       syncCount_r;

	// sysref synchroniser and edge detect
	logic             sysrefMeta_r;
	logic             sysrefSync_r;
	logic             sysrefPrev_r;

	// datapath state
	logic [PH_W-1:0]  phaseAcc_r;
	logic             fsFlip_r;
	logic [1:0]       c2rPhase_r;
	logic [CNT_W-1:0] decCnt_r;
	logic             outValid_r;
	logic [SMP_W-1:0] outI_r;
	logic [SMP_W-1:0] outQ_r;
	logic             oscRestart_r;

	// bus decode
	logic             busReq;
	logic             wrStrobe;
	logic             hitSync;
	logic             hitChan;
	logic             hitAux;
	logic             hitStatus;
	logic             hitFtw;
	logic             hitPow;
	logic [DAT_W-1:0] rdMux;
	logic [DAT_W-1:0] statusWord;
	logic [DAT_W-1:0] byteMask;

	assign busReq    = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wrStrobe  = busReq & wb_we_i;
	assign hitSync   = wb_adr_i == SYNC_CTRL_OFS;
	assign hitChan   = wb_adr_i == CHAN_CTRL_OFS;
	assign hitAux    = wb_adr_i == AUX_CTRL_OFS;
	assign hitStatus = wb_adr_i == STATUS_OFS;
	assign hitFtw    = wb_adr_i == FTW_OFS;
	assign hitPow    = wb_adr_i == POW_OFS;
	assign byteMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// channel control fields
	logic            complexMix;
	logic            gainEn;
	ddcc_if_mode_t   ifMode;
	logic            c2rEn;
	logic [2:0]      decCode;
	logic [3:0]      extRate;
	logic            sysrefEn;

	assign complexMix = chanCtrl_r[MIX_SEL_BIT];
	assign gainEn     = chanCtrl_r[GAIN_BIT];
	assign ifMode     = ddcc_if_mode_t'(chanCtrl_r[IF_MODE_LSB +: 2]);
	assign c2rEn      = chanCtrl_r[C2R_BIT];
	assign decCode    = chanCtrl_r[DEC_LSB +: 3];
	assign extRate    = auxCtrl_r[EXT_RATE_LSB +: 4];
	assign sysrefEn   = auxCtrl_r[SREF_EN_BIT];

	// sync event
	logic sysrefEdge;
	logic syncFire;
	logic oneShotDone;

	assign sysrefEdge  = sysrefSync_r & ~sysrefPrev_r & sysrefEn;
	assign syncFire    = sysrefEdge & syncCtrl_r[SYNC_EN_BIT];
	assign oneShotDone = syncFire & syncCtrl_r[SYNC_ONESHOT_BIT];

	// a software write in the same cycle as the one-shot clear wins, so re-arming is never lost
	always_comb
	begin
		syncCtrl_nxt = syncCtrl_r;
		if (wrStrobe && hitSync && wb_sel_i[0])
			syncCtrl_nxt = {6'h00, wb_dat_i[1:0]};
		else if (oneShotDone)
			syncCtrl_nxt[SYNC_EN_BIT] = 1'b0;
	end

	// filter chain and decimation factor for a code
	function automatic logic [12:0] chainDecode(input logic [2:0] code, input logic [3:0] ext, input logic real1);
		logic [4:0] chain;
		logic [7:0] cplx;
		logic [7:0] factor;
		chain  = 5'h00;
		cplx   = 8'h00;
		factor = 8'h00;
		case (code)
			DEC_HB12:   begin chain = CHAIN_HB1 | CHAIN_HB2;                         cplx = 8'h04; end
			DEC_HB123:  begin chain = CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3;             cplx = 8'h08; end
			DEC_HB1234: begin chain = CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3 | CHAIN_HB4; cplx = 8'h10; end
			DEC_HB1:    begin chain = CHAIN_HB1;                                     cplx = 8'h02; end
			DEC_HB1TB:  begin chain = CHAIN_HB1 | CHAIN_TB2;                         cplx = 8'h06; end
			DEC_HB12TB: begin chain = CHAIN_HB1 | CHAIN_HB2 | CHAIN_TB2;             cplx = 8'h0c; end
			DEC_HB3TB:  begin chain = CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3 | CHAIN_TB2; cplx = 8'h18; end
			default:
			begin
				case (ext)
					4'h0:    begin chain = 5'h1f; cplx = 8'h30; end
					4'h2:    cplx = 8'h0a;
					4'h3:    cplx = 8'h14;
					4'h4:    cplx = 8'h28;
					default: cplx = 8'h00;
				endcase
			end
		endcase
		factor = real1 ? {1'b0, cplx[7:1]} : cplx;
		if (code == DEC_EXT)
		begin
			case (ext)
				4'h7:    factor = 8'h03;
				4'h8:    factor = 8'h0f;
				4'h9:    factor = 8'h1e;
				default: factor = factor;
			endcase
		end
		return {chain, factor};
	endfunction

	logic [12:0]      chainWord;
	logic [4:0]       chainMask;
	logic [7:0]       decFactor;
	logic [CNT_W-1:0] decLast;
	logic             decHit;

	assign chainWord = chainDecode(decCode, extRate, c2rEn);
	assign chainMask = chainWord[12:8];
	assign decFactor = chainWord[7:0];
	assign decLast   = CNT_W'(decFactor - 8'h01);
	assign decHit    = (decFactor != 8'h00) && (decCnt_r == decLast);

	// mixer input selection
	logic signed [SMP_W-1:0] mixI;
	logic signed [SMP_W-1:0] mixQ;

	assign mixI = chanASample;
	assign mixQ = complexMix ? chanBSample : chanASample;

	// quarter-turn rotation; quadrant from the oscillator, IF mode and real conversion
	logic [1:0]            ifQuad;
	logic [1:0]            rotQuad;
	logic signed [SMP_W:0] extI;
	logic signed [SMP_W:0] extQ;
	logic signed [SMP_W:0] rotI;
	logic signed [SMP_W:0] rotQ;
	logic signed [SMP_W:0] preI;
	logic signed [SMP_W:0] preQ;
	logic [SMP_W-1:0]      gainI;
	logic [SMP_W-1:0]      gainQ;

	assign ifQuad  = (ifMode == IF_VARIABLE) ? phaseAcc_r[PH_W-1 -: 2] :
	                 (ifMode == IF_FS)       ? {fsFlip_r, 1'b0} :
	                 2'b00;
	assign rotQuad = ifQuad + (c2rEn ? c2rPhase_r : 2'b00);
	assign extI    = {mixI[SMP_W-1], mixI};
	assign extQ    = {mixQ[SMP_W-1], mixQ};
	assign rotI    = (rotQuad == 2'd0) ? extI :
	                 (rotQuad == 2'd1) ? -extQ :
	                 (rotQuad == 2'd2) ? -extI : extQ;
	assign rotQ    = (rotQuad == 2'd0) ? extQ :
	                 (rotQuad == 2'd1) ? extI :
	                 (rotQuad == 2'd2) ? -extQ : -extI;
	assign preI    = (ifMode == IF_TEST) ? {1'b0, TEST_LEVEL} : rotI;
	assign preQ    = (ifMode == IF_TEST) ? '0 : rotQ;

	ddcc_gain_sat gainStageI (
		.din    (preI),
		.gainEn (gainEn),
		.dout   (gainI)
	);

	ddcc_gain_sat gainStageQ (
		.din    (preQ),
		.gainEn (gainEn),
		.dout   (gainQ)
	);

	assign statusWord = {8'h00, syncCount_r, decFactor, 3'b000, chainMask};

	assign rdMux = hitSync   ? {24'h0, syncCtrl_r} :
	               hitChan   ? {24'h0, chanCtrl_r} :
	               hitAux    ? {24'h0, auxCtrl_r} :
	               hitStatus ? statusWord :
	               hitFtw    ? ftw_r :
	               hitPow    ? pow_r :
	               '0;

	// wishbone slave: ack one cycle after the request, unmapped reads return zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ack_r    <= 1'b0;
			rdData_r <= '0;
		end
		else
		begin
			ack_r    <= busReq;
			rdData_r <= (busReq && !wb_we_i) ? rdMux : '0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			syncCtrl_r <= SYNC_CTRL_RST;
			chanCtrl_r <= CHAN_CTRL_RST;
			auxCtrl_r  <= AUX_CTRL_RST;
			ftw_r      <= FTW_RST;
			pow_r      <= POW_RST;
		end
		else
		begin
			syncCtrl_r <= syncCtrl_nxt;
			if (wrStrobe && hitChan && wb_sel_i[0])
				chanCtrl_r <= wb_dat_i[7:0];
			if (wrStrobe && hitAux && wb_sel_i[0])
				auxCtrl_r <= {wb_dat_i[7], 3'b000, wb_dat_i[3:0]};
			if (wrStrobe && hitFtw)
				ftw_r <= (ftw_r & ~byteMask) | (wb_dat_i & byteMask);
			if (wrStrobe && hitPow)
				pow_r <= (pow_r & ~byteMask) | (wb_dat_i & byteMask);
		end
	end

	// sysref pin passes two flops before the edge detector
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			sysrefMeta_r <= 1'b0;
			sysrefSync_r <= 1'b0;
			sysrefPrev_r <= 1'b0;
		end
		else
		begin
			sysrefMeta_r <= sysrefIn;
			sysrefSync_r <= sysrefMeta_r;
			sysrefPrev_r <= sysrefSync_r;
		end
	end

	// oscillator, rotation phases and decimation counter restart on a sync edge
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			phaseAcc_r   <= '0;
			fsFlip_r     <= 1'b0;
			c2rPhase_r   <= 2'b00;
			decCnt_r     <= '0;
			syncCount_r  <= 8'h00;
			oscRestart_r <= 1'b0;
		end
		else
		begin
			oscRestart_r <= syncFire;
			if (syncFire)
			begin
				phaseAcc_r  <= pow_r;
				fsFlip_r    <= 1'b0;
				c2rPhase_r  <= 2'b00;
				decCnt_r    <= '0;
				syncCount_r <= syncCount_r + 8'h01;
			end
			else if (sampleValid)
			begin
				phaseAcc_r <= phaseAcc_r + ftw_r;
				fsFlip_r   <= ~fsFlip_r;
				c2rPhase_r <= c2rPhase_r + 2'b01;
				decCnt_r   <= decHit ? '0 : decCnt_r + 1'b1;
			end
		end
	end

	// decimated output register; real output forces Q to zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			outValid_r <= 1'b0;
			outI_r     <= '0;
			outQ_r     <= '0;
		end
		else
		begin
			outValid_r <= sampleValid & ~syncFire & decHit;
			if (sampleValid && !syncFire && decHit)
			begin
				outI_r <= gainI;
				outQ_r <= c2rEn ? '0 : gainQ;
			end
		end
	end

	assign wb_ack_o   = ack_r;
	assign wb_dat_o   = rdData_r;
	assign outValid   = outValid_r;
	assign outI       = outI_r;
	assign outQ       = outQ_r;
	assign oscRestart = oscRestart_r;

endmodule

// >>> ddcc_channel_monitor.sv
// port assertions for the downconverter channel control
`timescale 1ns/10ps
module ddcc_channel_monitor
	import ddcc_pkg::*;
(
	input wire logic             sys_clk,
	input wire logic             rst_n,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [DAT_W-1:0] wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             sysrefIn,
	input wire logic             sampleValid,
	input wire logic             outValid,
	input wire logic [SMP_W-1:0] outI,
	input wire logic [SMP_W-1:0] outQ,
	input wire logic             oscRestart
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!(wb_ack_o && !$past(wb_we_i)) |-> wb_dat_o == 32'h0)
		else $error("read data outside read ack");
	restart_pulse_a: assert property (oscRestart |=> !oscRestart)
		else $error("restart longer than one cycle");
	restart_cause_a: assert property (oscRestart |-> $past(sysrefIn, 3) && $past(sysrefIn, 2))
		else $error("restart without reference edge");
	valid_cause_a: assert property (outValid |-> $past(sampleValid))
		else $error("output without input sample");
	out_hold_a: assert property (!outValid |-> $stable(outI) && $stable(outQ))
		else $error("output changed without valid");
	reset_quiet_a: assert property ($rose(rst_n) |-> !wb_ack_o && !outValid && !oscRestart)
		else $error("output active after reset");
	cover property (oscRestart);
	cover property (outValid && outQ == 16'h0);
	cover property (wb_ack_o && !$past(wb_we_i));
endmodule
bind ddcc_channel_ctrl ddcc_channel_monitor u_ddcc_channel_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sysrefIn(sysrefIn), .sampleValid(sampleValid), .outValid(outValid), .outI(outI), .outQ(outQ),
	.oscRestart(oscRestart));

// >>> ddcc_conv_src.sv
// converter side source of samples and reference edges
`timescale 1ns/10ps
module ddcc_conv_src
	import ddcc_pkg::*;
(
	input wire logic         sys_clk,
	output logic             sysrefIn,
	output logic             sampleValid,
	output logic [SMP_W-1:0] chanASample,
	output logic [SMP_W-1:0] chanBSample
);
	initial
	begin
		sysrefIn = 1'h0;
		sampleValid = 1'h0;
		chanASample = 16'h0;
		chanBSample = 16'h0;
	end
	// idle lines show the inverse so stale data never matches
	task automatic sendPair(input logic [SMP_W-1:0] a0, b0, a1, b1);
		sampleValid <= 1'h1;
		chanASample <= a0;
		chanBSample <= b0;
		@(posedge sys_clk);
		chanASample <= a1;
		chanBSample <= b1;
		@(posedge sys_clk);
		sampleValid <= 1'h0;
		chanASample <= ~a1;
		chanBSample <= ~b1;
	endtask
	// fixed period keeps the reference a whole multiple of the oscillator
	task automatic pulseRef();
		sysrefIn <= 1'h1;
		repeat (6) @(posedge sys_clk);
		sysrefIn <= 1'h0;
		repeat (10) @(posedge sys_clk);
	endtask
endmodule

// >>> ddcc_gain_sat.sv
// optional 6 dB gain stage with saturation to sample width
`timescale 1ns/10ps
module ddcc_gain_sat
	import ddcc_pkg::*;
(
	input  wire logic signed [SMP_W:0]   din,
	input  wire logic                    gainEn,
	output logic signed [SMP_W-1:0]      dout
);

	logic signed [SMP_W+1:0] scaled;
	logic                    tooHigh;
	logic                    tooLow;

	assign scaled  = gainEn ? {din, 1'b0} : {din[SMP_W], din};
	assign tooHigh = ~scaled[SMP_W+1] & (scaled[SMP_W:SMP_W-1] != 2'b00);
	assign tooLow  = scaled[SMP_W+1] & (scaled[SMP_W:SMP_W-1] != 2'b11);
	assign dout    = tooHigh ? {1'b0, {(SMP_W-1){1'b1}}} :
	                 tooLow  ? {1'b1, {(SMP_W-1){1'b0}}} :
	                 scaled[SMP_W-1:0];

endmodule

// >>> ddcc_pkg.sv
// shared constants and types for the downconverter channel control block
package ddcc_pkg;

	localparam int unsigned ADR_W = 12;
	localparam int unsigned DAT_W = 32;
	localparam int unsigned SMP_W = 16;
	localparam int unsigned PH_W  = 32;
	localparam int unsigned CNT_W = 6;

	// register byte offsets
	localparam logic [ADR_W-1:0] SYNC_CTRL_OFS = 12'h300;
	localparam logic [ADR_W-1:0] CHAN_CTRL_OFS = 12'h310;
	localparam logic [ADR_W-1:0] AUX_CTRL_OFS  = 12'h320;
	localparam logic [ADR_W-1:0] STATUS_OFS    = 12'h324;
	localparam logic [ADR_W-1:0] FTW_OFS       = 12'h328;
	localparam logic [ADR_W-1:0] POW_OFS       = 12'h32c;

	// sync control fields
	localparam int unsigned SYNC_EN_BIT      = 0;
	localparam int unsigned SYNC_ONESHOT_BIT = 1;

	// channel control fields
	localparam int unsigned MIX_SEL_BIT = 7;
	localparam int unsigned GAIN_BIT    = 6;
	localparam int unsigned IF_MODE_LSB = 4;
	localparam int unsigned C2R_BIT     = 3;
	localparam int unsigned DEC_LSB     = 0;

	// auxiliary control fields
	localparam int unsigned SREF_EN_BIT  = 7;
	localparam int unsigned EXT_RATE_LSB = 0;

	// status fields
	localparam int unsigned STAT_CHAIN_LSB  = 0;
	localparam int unsigned STAT_FACTOR_LSB = 8;
	localparam int unsigned STAT_COUNT_LSB  = 16;

	// reset values
	localparam logic [7:0]      SYNC_CTRL_RST = 8'h00;
	localparam logic [7:0]      CHAN_CTRL_RST = 8'h00;
	localparam logic [7:0]      AUX_CTRL_RST  = 8'h00;
	localparam logic [PH_W-1:0] FTW_RST       = 32'h0000_0000;
	localparam logic [PH_W-1:0] POW_RST       = 32'h0000_0000;

	// decimation codes
	localparam logic [2:0] DEC_HB12   = 3'h0;
	localparam logic [2:0] DEC_HB123  = 3'h1;
	localparam logic [2:0] DEC_HB1234 = 3'h2;
	localparam logic [2:0] DEC_HB1    = 3'h3;
	localparam logic [2:0] DEC_HB1TB  = 3'h4;
	localparam logic [2:0] DEC_HB12TB = 3'h5;
	localparam logic [2:0] DEC_HB3TB  = 3'h6;
	localparam logic [2:0] DEC_EXT    = 3'h7;

	// filter chain mask: halfband one..four in bits 0..3, thirdband two in bit 4
	localparam logic [4:0] CHAIN_HB1 = 5'h01;
	localparam logic [4:0] CHAIN_HB2 = 5'h02;
	localparam logic [4:0] CHAIN_HB3 = 5'h04;
	localparam logic [4:0] CHAIN_HB4 = 5'h08;
	localparam logic [4:0] CHAIN_TB2 = 5'h10;

	// full-scale level sent in test mode
	localparam logic [SMP_W-1:0] TEST_LEVEL = 16'h7fff;

	typedef enum logic [1:0] {
		IF_VARIABLE,
		IF_ZERO,
		IF_FS,
		IF_TEST
	} ddcc_if_mode_t;

endpackage

// >>> testbench.sv
// self-checking bench for the downconverter channel control
`timescale 1ns/10ps
module testbench
	import ddcc_pkg::*;
;
	logic             sys_clk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [ADR_W-1:0] wb_adr_i = 12'h0;
	logic [3:0]       wb_sel_i = 4'h0;
	logic [DAT_W-1:0] wb_dat_i = 32'h0, wb_dat_o;
	logic             wb_ack_o, sysrefIn, sampleValid, outValid, oscRestart;
	logic [SMP_W-1:0] chanASample, chanBSample, outI, outQ;
	int               err_count = 0, n_checks = 0, seed = 36820, nRestart = 0;
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (oscRestart === 1'h1) nRestart++;
	ddcc_channel_ctrl u_ddcc_channel_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sysrefIn(sysrefIn), .sampleValid(sampleValid),
		.chanASample(chanASample), .chanBSample(chanBSample), .outValid(outValid), .outI(outI), .outQ(outQ),
		.oscRestart(oscRestart));
	ddcc_conv_src u_ddcc_conv_src (.sys_clk(sys_clk), .sysrefIn(sysrefIn), .sampleValid(sampleValid),
		.chanASample(chanASample), .chanBSample(chanBSample));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [DAT_W-1:0] exp, got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wbCycle(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] wd,
		output logic [DAT_W-1:0] rd);
		int   n;
		logic ok;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hf;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (wb_ack_o !== 1'h1 && n < 16);
		ok = (wb_ack_o === 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge sys_clk);
		if (!ok)
		begin
			err_count++;
			summarize();
		end
	endtask
	task automatic wr(input logic [ADR_W-1:0] adr, input logic [7:0] d);
		logic [DAT_W-1:0] rd;
		wbCycle(1'h1, adr, {24'h0, d}, rd);
	endtask
	task automatic rdChk(input string what, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp, mask);
		logic [DAT_W-1:0] rd;
		wbCycle(1'h0, adr, 32'h0, rd);
		check(what, exp, rd & mask);
	endtask
	function automatic logic [15:0] expStat(input logic [2:0] code, input logic c2r);
		logic [7:0] f;
		logic [4:0] m;
		case (code)
			3'h0: {f, m} = {8'h04, CHAIN_HB1 | CHAIN_HB2};
			3'h1: {f, m} = {8'h08, CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3};
			3'h2: {f, m} = {8'h10, CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3 | CHAIN_HB4};
			3'h3: {f, m} = {8'h02, CHAIN_HB1};
			3'h4: {f, m} = {8'h06, CHAIN_HB1 | CHAIN_TB2};
			3'h5: {f, m} = {8'h0c, CHAIN_HB1 | CHAIN_HB2 | CHAIN_TB2};
			default: {f, m} = {8'h18, CHAIN_HB1 | CHAIN_HB2 | CHAIN_HB3 | CHAIN_TB2};
		endcase
		return {c2r ? f >> 1 : f, 3'h0, m};
	endfunction
	function automatic logic [SMP_W-1:0] sat(input logic signed [SMP_W+1:0] v);
		if (v > 18'sh07fff)
			return 16'h7fff;
		if (v < -18'sh08000)
			return 16'h8000;
		return v[SMP_W-1:0];
	endfunction
	function automatic logic [31:0] expIQ(input logic [7:0] ctl, input logic signed [SMP_W-1:0] a, b,
		input logic [1:0] quad);
		logic signed [SMP_W+1:0] i, q, t;
		i = a;
		q = ctl[7] ? b : a;
		if (ctl[5:4] == 2'h3)
			return {TEST_LEVEL, 16'h0};
		// quarter-turn rotation of the mixer output
		t = i;
		case (quad)
			2'h1:
			begin
				i = -q;
				q = t;
			end
			2'h2:
			begin
				i = -i;
				q = -q;
			end
			2'h3:
			begin
				i = q;
				q = -t;
			end
			default: t = i;
		endcase
		if (ctl[6])
		begin
			i = i <<< 1;
			q = q <<< 1;
		end
		return {sat(i), sat(q)};
	endfunction
	initial
	begin
		logic [7:0]       ctl;
		logic [SMP_W-1:0] a0, b0, a1, b1;
		logic [DAT_W-1:0] rd, e;
		logic [1:0]       quad;
		logic [7:0]       modes [7] = '{8'h83, 8'h93, 8'hd3, 8'h13, 8'ha3, 8'hb3, 8'h9b};
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		rdChk("sync reset", SYNC_CTRL_OFS, 32'h0, 32'hffffffff);
		rdChk("ctrl reset", CHAN_CTRL_OFS, 32'h0, 32'hffffffff);
		rdChk("unmapped", 12'h3f0, 32'h0, 32'hffffffff);
		ctl = $random(seed);
		wr(CHAN_CTRL_OFS, ctl);
		rdChk("ctrl rw", CHAN_CTRL_OFS, {24'h0, ctl}, 32'hffffffff);
		wr(SYNC_CTRL_OFS, 8'hff);
		rdChk("sync rw", SYNC_CTRL_OFS, 32'h3, 32'hffffffff);
		for (int k = 0; k < 14; k++)
		begin
			wr(CHAN_CTRL_OFS, {4'h0, k[0], k[3:1]});
			rdChk("chain", STATUS_OFS, {16'h0, expStat(k[3:1], k[0])}, 32'hffff);
		end
		for (int k = 7; k < 10; k++)
		begin
			wr(AUX_CTRL_OFS, k[7:0]);
			wr(CHAN_CTRL_OFS, {4'h0, k[0], DEC_EXT});
			rdChk("ext factor", STATUS_OFS, {16'h0, k == 7 ? 8'h03 : k == 8 ? 8'h0f : 8'h1e, 8'h0}, 32'hff00);
		end
		$display("test registers done");
		// quarter turn per sample and a half-turn offset loaded at every sync
		wbCycle(1'h1, FTW_OFS, 32'h4000_0000, rd);
		wbCycle(1'h1, POW_OFS, 32'h8000_0000, rd);
		rdChk("osc step", FTW_OFS, 32'h4000_0000, 32'hffffffff);
		rdChk("osc offset", POW_OFS, 32'h8000_0000, 32'hffffffff);
		wr(AUX_CTRL_OFS, 8'h80);
		wr(SYNC_CTRL_OFS, 8'h03);
		repeat (2) u_ddcc_conv_src.pulseRef();
		check("one shot", 32'h1, nRestart);
		rdChk("one shot clear", SYNC_CTRL_OFS, 32'h2, 32'hffffffff);
		wr(SYNC_CTRL_OFS, 8'h01);
		repeat (2) u_ddcc_conv_src.pulseRef();
		rdChk("continuous", SYNC_CTRL_OFS, 32'h1, 32'hffffffff);
		wr(AUX_CTRL_OFS, 8'h00);
		u_ddcc_conv_src.pulseRef();
		wr(AUX_CTRL_OFS, 8'h80);
		wr(SYNC_CTRL_OFS, 8'h00);
		u_ddcc_conv_src.pulseRef();
		check("restarts", 32'h3, nRestart);
		rdChk("event count", STATUS_OFS, 32'h30000, 32'hff0000);
		$display("test sync done");
		for (int k = 0; k < 14; k++)
		begin
			ctl = modes[k >> 1];
			if (k[0] == 1'h0)
				wr(CHAN_CTRL_OFS, ctl);
			a0 = $random(seed);
			b0 = $random(seed);
			a1 = (k == 4) ? 16'h7000 : $random(seed);
			b1 = (k == 4) ? 16'h9000 : $random(seed);
			u_ddcc_conv_src.sendPair(a0, b0, a1, b1);
			for (int n = 0; n < 8 && outValid !== 1'h1; n++)
				@(posedge sys_clk);
			check("valid", 32'h1, {31'h0, outValid});
			if (outValid !== 1'h1)
				summarize();
			// quadrant of the second sample of a pair: variable IF is offset half turn plus one or three quarters, half-rate IF half a turn, else zero
			quad = (ctl[5:4] == 2'h0) ? {~k[0], 1'h1} : (ctl[5:4] == 2'h2) ? 2'h2 : 2'h0;
			if (ctl[3])
			begin
				e = expIQ(ctl, a0, b0, {k[0], 1'h0});
				check("real q", 32'h0, {16'h0, outQ});
				check("real i", {16'h0, e[31:16]}, {16'h0, outI});
			end
			else
				check("iq", expIQ(ctl, a1, b1, quad), {outI, outQ});
			@(posedge sys_clk);
		end
		$display("test stream done");
		summarize();
	end
endmodule
